// ===== core/dcs_ctrl.v
// acquisition board control word, status word, request and trigger routing
//
// Decided for this implementation: the APB register port.
`include "dcs_map.vh"

module dcs_ctrl #(
   parameter LEVEL_W   = 9,     // fifo level width
   parameter FIFO_HALF = 128    // half-full threshold in conversions
) (
   input  wire               CLK,             // 250 MHz clock
   input  wire               RST,             // async reset, active high
   input  wire               PSEL,            // apb select
   input  wire               PENABLE,         // apb access phase
   input  wire               PWRITE,          // apb direction
   input  wire [7:0]         PADDR,           // apb byte address
   input  wire [31:0]        PWDATA,          // apb write data
   output reg  [31:0]        PRDATA,          // apb read data
   output reg                PREADY,          // apb ready
   output reg                PSLVERR,         // apb error on unmapped address
   input  wire               ACQ_START,       // acquisition trigger pulse
   input  wire               ACQ_END,         // sequence ran its course pulse
   input  wire               OVERRUN_N,       // conversion overrun, active low
   input  wire               OVERFLOW_N,      // fifo overflow, active low
   input  wire [LEVEL_W-1:0] FIFO_LEVEL,      // conversions held in adc fifo
   input  wire               DAC_WRITE,       // host wrote either dac
   input  wire               EXT_DAC_UPDATE_N,// external dac update input
   input  wire               DMA_TC_A,        // terminal count pulse channel a
   input  wire               DMA_TC_B,        // terminal count pulse channel b
   input  wire               CNT_FIVE_OUT,    // counter five output
   input  wire               CNT_TWO_OUT,     // counter two output
   input  wire               PIN4_I,          // trigger bus pin4 level
   output reg                PIN4_O,          // trigger bus pin4 drive value
   output reg                PIN4_OE,         // trigger bus pin4 enable
   input  wire               PIN2_I,          // trigger bus pin2 level
   output reg                PIN2_O,          // trigger bus pin2 drive value
   output reg                PIN2_OE,         // trigger bus pin2 enable
   output reg                CNT_ONE_GATE_O,  // counter one gate from pin2
   output reg                CNT_ONE_GATE_OE, // trigger bus drives gate
   output reg  [3:0]         PORT_A_O,        // digital port a value
   output reg                PORT_A_OE,       // digital port a enable
   output reg  [3:0]         PORT_B_O,        // digital port b value
   output reg                PORT_B_OE,       // digital port b enable
   output reg                DAC_LOAD,        // update both dacs, pulse
   output reg  [1:0]         DAC_TARGET,      // output dma target analog_out_zero/analog_out_one
   output reg                ACQ_BUSY,        // acquisition running
   output reg                ACQ_CLEAR,       // clear acquisition circuitry, pulse
   output reg                IRQ,             // board interrupt request
   output reg                DMA_REQ_A,       // dma request channel a
   output reg                DMA_REQ_B        // dma request channel b
);

   reg  [15:0] ctl_q;
   reg  [7:0]  dig_q;
   reg         busy_q;
   reg         trig_prev_q;

   wire [4:0] mode = {ctl_q[`DCS_CTL_IRQ_EN], ctl_q[`DCS_CTL_DMA_EN],
                      ctl_q[`DCS_CTL_MODE_HI:`DCS_CTL_MODE_LO]};

   // apb decode; writes land on the edge where pready is seen high
   wire access   = PSEL & PENABLE;
   wire wr_fire  = access & PREADY & PWRITE;
   wire mapped   = (PADDR == `DCS_OFF_STATUS)  | (PADDR == `DCS_OFF_CONTROL) |
                   (PADDR == `DCS_OFF_ACQ_CLR) | (PADDR == `DCS_OFF_TC_CLR)  |
                   (PADDR == `DCS_OFF_DAC_UPD) | (PADDR == `DCS_OFF_DACUP_CLR) |
                   (PADDR == `DCS_OFF_DIG_OUT);
   wire acq_clr_wr  = wr_fire & (PADDR == `DCS_OFF_ACQ_CLR);
   wire tc_clr_wr   = wr_fire & (PADDR == `DCS_OFF_TC_CLR);
   wire dac_upd_wr  = wr_fire & (PADDR == `DCS_OFF_DAC_UPD);
   wire dacup_clr_wr = wr_fire & (PADDR == `DCS_OFF_DACUP_CLR);

   // fifo thresholds
   wire fifo_some = (FIFO_LEVEL != {LEVEL_W{1'b0}});
   wire fifo_half = (FIFO_LEVEL >= FIFO_HALF[LEVEL_W-1:0]);

   // dac trigger source and falling edge
   // switching the source while the new one sits low looks like an edge
   wire trig_n    = ctl_q[`DCS_CTL_P4_RCV] ? PIN4_I : EXT_DAC_UPDATE_N;
   wire trig_fall = trig_prev_q & ~trig_n;

   // acquisition termination: own end or an error cuts it short
   wire acq_term = busy_q & (ACQ_END | ~OVERRUN_N | ~OVERFLOW_N);

   wire done_flag;
   wire tc_flag;
   wire dacup_flag;
   wire pair_stop;

   // completion flag; only the clear strobe removes it
   dcs_flag u_done (
      .CLK  (CLK),
      .RST  (RST),
      .SET  (acq_term),
      .CLR  (acq_clr_wr),
      .FLAG (done_flag)
   );

   // terminal count flag from either channel
   dcs_flag u_tc (
      .CLK  (CLK),
      .RST  (RST),
      .SET  (DMA_TC_A | DMA_TC_B),
      .CLR  (tc_clr_wr),
      .FLAG (tc_flag)
   );

   // dac update event flag, set on trigger falling edge
   dcs_flag u_dacup (
      .CLK  (CLK),
      .RST  (RST),
      .SET  (trig_fall),
      .CLR  (dacup_clr_wr),
      .FLAG (dacup_flag)
   );

   reg sel_fifo_irq, sel_dac_irq, a_adc, a_dac, b_adc, b_dac, locked;

   // locked pair: a count on either channel halts both until tc clear
   dcs_flag u_pair (
      .CLK  (CLK),
      .RST  (RST),
      .SET  (locked & (DMA_TC_A | DMA_TC_B)),
      .CLR  (tc_clr_wr),
      .FLAG (pair_stop)
   );

   // mode code decode
   always @* begin
      sel_fifo_irq = 1'b0;
      sel_dac_irq  = 1'b0;
      a_adc        = 1'b0;
      a_dac        = 1'b0;
      b_adc        = 1'b0;
      b_dac        = 1'b0;
      locked       = 1'b0;
      case (mode)
         `DCS_M_IN_A: a_adc = 1'b1;
         `DCS_M_OUT_A0, `DCS_M_OUT_A1, `DCS_M_OUT_A01: a_dac = 1'b1;
         `DCS_M_IN_AB: begin
            a_adc = 1'b1;
            b_adc = 1'b1;
         end
         `DCS_M_IO_B0, `DCS_M_IO_B1, `DCS_M_IO_B01: begin
            a_adc = 1'b1;
            b_dac = 1'b1;
         end
         `DCS_M_FIFO_IRQ: sel_fifo_irq = 1'b1;
         `DCS_M_DAC_IRQ:  sel_dac_irq  = 1'b1;
         `DCS_M_BOTH_IRQ: begin
            sel_fifo_irq = 1'b1;
            sel_dac_irq  = 1'b1;
         end
         `DCS_M_IN_A_DI: begin
            a_adc       = 1'b1;
            sel_dac_irq = 1'b1;
         end
         `DCS_M_OUT_A0_FI, `DCS_M_OUT_A1_FI, `DCS_M_OUT_A01_FI: begin
            a_dac        = 1'b1;
            sel_fifo_irq = 1'b1;
         end
         `DCS_M_IN_AB_DI: begin
            a_adc       = 1'b1;
            b_adc       = 1'b1;
            sel_dac_irq = 1'b1;
         end
         `DCS_M_PAIR: begin
            a_dac  = 1'b1;
            b_dac  = 1'b1;
            locked = 1'b1;
         end
         `DCS_M_PAIR_FI: begin
            a_dac        = 1'b1;
            b_dac        = 1'b1;
            locked       = 1'b1;
            sel_fifo_irq = 1'b1;
         end
         default: sel_fifo_irq = 1'b0; // remaining codes request nothing
      endcase
   end

   // adc request: one conversion or half-full, drain to empty after completion
   reg fifo_req;
   always @* begin
      if (ctl_q[`DCS_CTL_FIFO_THR]) begin
         fifo_req = fifo_half | (done_flag & fifo_some);
      end else begin
         fifo_req = fifo_some;
      end
   end

   // interrupt sources; mode interrupts need the global bit inside the code
   wire irq_d = (ctl_q[`DCS_CTL_TC_IRQ_EN] & tc_flag) |
                (ctl_q[`DCS_CTL_DONE_EN] & done_flag) |
                (sel_fifo_irq & fifo_req) |
                (sel_dac_irq & dacup_flag);

   // dma requests; no request at all with the enable clear
   wire dma_go  = ctl_q[`DCS_CTL_DMA_EN] & ~pair_stop;
   wire dma_a_d = dma_go & ((a_adc & fifo_req) | (a_dac & dacup_flag));
   wire dma_b_d = dma_go & ((b_adc & fifo_req) | (b_dac & dacup_flag));

   // dac load: direct on write, or trigger/strobe in waveform mode
   wire dac_load_d = ctl_q[`DCS_CTL_WAVEFORM_GEN_EN] ? (trig_fall | dac_upd_wr)
                                          : DAC_WRITE;

   // retrigger allowed only when idle and, under hold, after the clear
   wire start_ok = ACQ_START & ~busy_q &
                   ~(ctl_q[`DCS_CTL_RETRIGGER_HOLD] & done_flag);

   // status word assembly
   wire [15:0] status_w;
   assign status_w[`DCS_ST_DONE]      = done_flag;
   assign status_w[`DCS_ST_BUSY]      = busy_q;
   assign status_w[`DCS_ST_HALF_N]    = ~fifo_half;
   assign status_w[`DCS_ST_NOT_EMPTY] = fifo_some;
   assign status_w[`DCS_ST_TC]        = tc_flag;
   // per-channel count and calibration bits live outside this block, read zero
   assign status_w[`DCS_ST_RSV_HI:`DCS_ST_RSV_LO] = 2'h0;
   assign status_w[`DCS_ST_OVFL_N]    = OVERFLOW_N;
   assign status_w[`DCS_ST_OVRN_N]    = OVERRUN_N;
   assign status_w[`DCS_ST_DACUP]     = dacup_flag;
   assign status_w[`DCS_ST_LOW_MSB:0] = 6'h00;

   // apb slave: one wait state, ready and data from flops
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= access & ~PREADY;
         PSLVERR <= access & ~PREADY & ~mapped;
         if (access & ~PREADY & ~PWRITE & (PADDR == `DCS_OFF_STATUS)) begin
            PRDATA <= {16'h0000, status_w};
         end else begin
            PRDATA <= 32'h00000000; // write-only words read as zero
         end
      end
   end

   // writable registers; the control word has no read path, so software
   // has to keep its own copy of it
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctl_q <= `DCS_CTL_RESET;
         dig_q <= 8'h00;
      end else begin
         if (wr_fire & (PADDR == `DCS_OFF_CONTROL)) begin
            ctl_q <= PWDATA[15:0];
         end
         if (wr_fire & (PADDR == `DCS_OFF_DIG_OUT)) begin
            dig_q <= PWDATA[7:0];
         end
      end
   end

   // acquisition progress; clear strobe cancels a running sequence
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_q <= 1'b0;
      end else if (start_ok) begin
         busy_q <= 1'b1;
      end else if (acq_term | acq_clr_wr) begin
         busy_q <= 1'b0;
      end
   end

   // trigger history starts high so reset is not seen as an edge
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         trig_prev_q <= 1'b1;
      end else begin
         trig_prev_q <= trig_n;
      end
   end

   // registered outputs; adds one cycle of latency to every request
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN4_O          <= 1'b0;
         PIN4_OE         <= 1'b0;
         PIN2_O          <= 1'b0;
         PIN2_OE         <= 1'b0;
         CNT_ONE_GATE_O  <= 1'b0;
         CNT_ONE_GATE_OE <= 1'b0;
         PORT_A_O        <= 4'h0;
         PORT_A_OE       <= 1'b0;
         PORT_B_O        <= 4'h0;
         PORT_B_OE       <= 1'b0;
         DAC_LOAD        <= 1'b0;
         DAC_TARGET      <= 2'h0;
         ACQ_BUSY        <= 1'b0;
         ACQ_CLEAR       <= 1'b0;
         IRQ             <= 1'b0;
         DMA_REQ_A       <= 1'b0;
         DMA_REQ_B       <= 1'b0;
      end else begin
         PIN4_O          <= CNT_FIVE_OUT;
         PIN4_OE         <= ctl_q[`DCS_CTL_P4_DRV];
         PIN2_O          <= CNT_TWO_OUT;
         PIN2_OE         <= ctl_q[`DCS_CTL_P2_DRV];
         CNT_ONE_GATE_O  <= PIN2_I;
         CNT_ONE_GATE_OE <= ctl_q[`DCS_CTL_P2_RCV];
         PORT_A_O        <= dig_q[3:0];
         PORT_A_OE       <= ctl_q[`DCS_CTL_PORTA_EN];
         PORT_B_O        <= dig_q[7:4];
         PORT_B_OE       <= ctl_q[`DCS_CTL_PORTB_EN];
         DAC_LOAD        <= dac_load_d;
         DAC_TARGET      <= (a_dac | b_dac) ? mode[1:0] : 2'h0;
         ACQ_BUSY        <= busy_q;
         ACQ_CLEAR       <= acq_clr_wr;
         IRQ             <= irq_d;
         DMA_REQ_A       <= dma_a_d;
         DMA_REQ_B       <= dma_b_d;
      end
   end

endmodule // dcs_ctrl

// ===== core/dcs_flag.v
// sticky event flag with set-over-clear priority
module dcs_flag (
   input  wire CLK,    // system clock
   input  wire RST,    // async reset, active high
   input  wire SET,    // one-cycle set event
   input  wire CLR,    // one-cycle clear event
   output wire FLAG    // sticky flag
);

   reg flag_q;

   // set beats clear so an event in the clear cycle survives
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         flag_q <= 1'b0;
      end else if (SET) begin
         flag_q <= 1'b1;
      end else if (CLR) begin
         flag_q <= 1'b0;
      end
   end

   assign FLAG = flag_q;

endmodule // dcs_flag

// ===== core/dcs_map.vh
// register offsets, field positions and reset values of the control/status block
`ifndef DCS_MAP_VH
`define DCS_MAP_VH

// register byte offsets on the apb
`define DCS_OFF_STATUS     8'h00
`define DCS_OFF_CONTROL    8'h04
`define DCS_OFF_ACQ_CLR    8'h08
`define DCS_OFF_TC_CLR     8'h0C
`define DCS_OFF_DAC_UPD    8'h10
`define DCS_OFF_DACUP_CLR  8'h14
`define DCS_OFF_DIG_OUT    8'h18

// control word fields
`define DCS_CTL_PORTB_EN   15
`define DCS_CTL_PORTA_EN   14
`define DCS_CTL_WAVEFORM_GEN_EN       13
`define DCS_CTL_IRQ_EN     12
`define DCS_CTL_DMA_EN     11
`define DCS_CTL_TC_IRQ_EN  10
`define DCS_CTL_DONE_EN    9
`define DCS_CTL_MODE_HI    8
`define DCS_CTL_MODE_LO    6
`define DCS_CTL_FIFO_THR   5
`define DCS_CTL_RETRIGGER_HOLD     4
`define DCS_CTL_P4_RCV     3
`define DCS_CTL_P4_DRV     2
`define DCS_CTL_P2_RCV     1
`define DCS_CTL_P2_DRV     0
`define DCS_CTL_RESET      16'h0000

// status word fields
`define DCS_ST_DONE        15
`define DCS_ST_BUSY        14
`define DCS_ST_HALF_N      13
`define DCS_ST_NOT_EMPTY   12
`define DCS_ST_TC          11
`define DCS_ST_OVFL_N      8
`define DCS_ST_OVRN_N      7
`define DCS_ST_DACUP       6
`define DCS_ST_RSV_HI      10
`define DCS_ST_RSV_LO      9
`define DCS_ST_LOW_MSB     5

// five-bit interrupt/dma mode codes
`define DCS_M_IN_A         5'h08
`define DCS_M_OUT_A0       5'h09
`define DCS_M_OUT_A1       5'h0A
`define DCS_M_OUT_A01      5'h0B
`define DCS_M_IN_AB        5'h0C
`define DCS_M_IO_B0        5'h0D
`define DCS_M_IO_B1        5'h0E
`define DCS_M_IO_B01       5'h0F
`define DCS_M_FIFO_IRQ     5'h11
`define DCS_M_DAC_IRQ      5'h12
`define DCS_M_BOTH_IRQ     5'h13
`define DCS_M_IN_A_DI      5'h18
`define DCS_M_OUT_A0_FI    5'h19
`define DCS_M_OUT_A1_FI    5'h1A
`define DCS_M_OUT_A01_FI   5'h1B
`define DCS_M_IN_AB_DI     5'h1C
`define DCS_M_PAIR         5'h1E
`define DCS_M_PAIR_FI      5'h1F

`endif

// ===== verification/dcs_ctrl_sva.sv
// port assertions for the control/status block
module dcs_ctrl_sva (
   input wire        CLK,
   input wire        RST,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [7:0]  PADDR,
   input wire [31:0] PWDATA,
   input wire        PREADY,
   input wire        DAC_WRITE,
   input wire        DAC_LOAD,
   input wire        CNT_FIVE_OUT,
   input wire        CNT_TWO_OUT,
   input wire        PIN2_I,
   input wire        PIN4_O,
   input wire        PIN4_OE,
   input wire        PIN2_O,
   input wire        PIN2_OE,
   input wire        CNT_ONE_GATE_O,
   input wire        CNT_ONE_GATE_OE,
   input wire        PORT_A_OE,
   input wire        PORT_B_OE,
   input wire        ACQ_END,
   input wire        OVERRUN_N,
   input wire        ACQ_BUSY,
   input wire        ACQ_CLEAR,
   input wire        IRQ,
   input wire        DMA_REQ_A,
   input wire        DMA_REQ_B
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic [15:0] ctl_q;
   logic [15:0] ctl_p_q;
   wire         wr_ok = PSEL && PENABLE && PREADY && PWRITE;

   // shadow of the write-only control word; outputs lag it by one edge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctl_q   <= 16'h0000;
         ctl_p_q <= 16'h0000;
      end else begin
         if (wr_ok && PADDR == 8'h04) ctl_q <= PWDATA[15:0];
         ctl_p_q <= ctl_q;
      end
   end

   property p_port_en; PORT_A_OE == ctl_p_q[14] && PORT_B_OE == ctl_p_q[15]; endproperty
   a_port_en: assert property (p_port_en) else $error("port enable wrong");
   property p_pin_drv; PIN4_OE == ctl_p_q[2] && PIN2_OE == ctl_p_q[0]; endproperty
   a_pin_drv: assert property (p_pin_drv) else $error("pin drive enable wrong");
   property p_gate_en; CNT_ONE_GATE_OE == ctl_p_q[1]; endproperty
   a_gate_en: assert property (p_gate_en) else $error("gate enable wrong");
   property p_pin4_val; PIN4_OE |-> PIN4_O == $past(CNT_FIVE_OUT); endproperty
   a_pin4_val: assert property (p_pin4_val) else $error("pin4 value wrong");
   property p_pin2_val; PIN2_OE |-> PIN2_O == $past(CNT_TWO_OUT); endproperty
   a_pin2_val: assert property (p_pin2_val) else $error("pin2 value wrong");
   property p_gate_val; CNT_ONE_GATE_OE |-> CNT_ONE_GATE_O == $past(PIN2_I); endproperty
   a_gate_val: assert property (p_gate_val) else $error("gate value wrong");
   property p_dma_off; !ctl_p_q[11] |-> !DMA_REQ_A && !DMA_REQ_B; endproperty
   a_dma_off: assert property (p_dma_off) else $error("dma request while disabled");
   property p_irq_off; ctl_p_q[12:9] == 4'h0 |-> !IRQ; endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
   property p_dac_direct; !ctl_q[13] && DAC_WRITE |=> DAC_LOAD; endproperty
   a_dac_direct: assert property (p_dac_direct) else $error("dac write gave no load");
   property p_busy_end; ACQ_BUSY && ACQ_END |-> ##[1:2] !ACQ_BUSY; endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy after end");
   property p_busy_err; ACQ_BUSY && !OVERRUN_N |-> ##[1:2] !ACQ_BUSY; endproperty
   a_busy_err: assert property (p_busy_err) else $error("busy after overrun");
   property p_clr; wr_ok && PADDR == 8'h08 |=> ACQ_CLEAR; endproperty
   a_clr: assert property (p_clr) else $error("clear strobe gave no pulse");
endmodule // dcs_ctrl_sva

bind dcs_ctrl dcs_ctrl_sva dcs_ctrl_sva_inst (
   .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PREADY(PREADY), .DAC_WRITE(DAC_WRITE), .DAC_LOAD(DAC_LOAD),
   .CNT_FIVE_OUT(CNT_FIVE_OUT), .CNT_TWO_OUT(CNT_TWO_OUT), .PIN2_I(PIN2_I), .PIN4_O(PIN4_O),
   .PIN4_OE(PIN4_OE), .PIN2_O(PIN2_O), .PIN2_OE(PIN2_OE), .CNT_ONE_GATE_O(CNT_ONE_GATE_O),
   .CNT_ONE_GATE_OE(CNT_ONE_GATE_OE), .PORT_A_OE(PORT_A_OE), .PORT_B_OE(PORT_B_OE),
   .ACQ_END(ACQ_END), .OVERRUN_N(OVERRUN_N), .ACQ_BUSY(ACQ_BUSY), .ACQ_CLEAR(ACQ_CLEAR),
   .IRQ(IRQ), .DMA_REQ_A(DMA_REQ_A), .DMA_REQ_B(DMA_REQ_B));

// ===== verification/dcs_ctrl_tb.sv
// self-checking bench for the control/status block
module dcs_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, psel, penable, pwrite, dac_write, ext_dac_n, acq_start, acq_end;
   logic        overrun_n, overflow_n, cnt_five, cnt_two, pin4_drv, pin2_drv;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [8:0]  fifo_level;
   wire  [31:0] prdata;
   wire         pready, pslverr, pin4_o, pin4_oe, pin2_o, pin2_oe, gate_o, gate_oe, dac_load;
   wire         port_a_oe, port_b_oe, acq_busy, irq, req_a, req_b, tc_a, tc_b;
   wire  [3:0]  port_a_o, port_b_o;
   wire  [1:0]  dac_tgt;
   wire         pin4_w = pin4_oe ? pin4_o : pin4_drv;
   wire         pin2_w = pin2_oe ? pin2_o : pin2_drv;
   int          error_cnt = 0;
   int          num_checks = 0;
   // control word, fifo level; low byte: req b, check-a flag, dac target, irq, req a
   logic [31:0] mode_tbl [17] = '{32'h0000_0110, 32'h0800_0111, 32'h0900_0131, 32'h1040_0102,
      32'h1000_0110, 32'h1100_0110, 32'h1080_0100, 32'h18C0_010E, 32'h1800_0111,
      32'h1940_0110, 32'h0820_0110, 32'h0820_8011, 32'h1900_0131, 32'h0940_0115,
      32'h10C0_0102, 32'h19C0_010E, 32'h0880_0118};

   dcs_ctrl #(.LEVEL_W(9), .FIFO_HALF(128)) dcs_ctrl_inst (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ACQ_START(acq_start), .ACQ_END(acq_end), .OVERRUN_N(overrun_n), .OVERFLOW_N(overflow_n),
      .FIFO_LEVEL(fifo_level), .DAC_WRITE(dac_write), .EXT_DAC_UPDATE_N(ext_dac_n),
      .DMA_TC_A(tc_a), .DMA_TC_B(tc_b), .CNT_FIVE_OUT(cnt_five), .CNT_TWO_OUT(cnt_two),
      .PIN4_I(pin4_w), .PIN4_O(pin4_o), .PIN4_OE(pin4_oe), .PIN2_I(pin2_w), .PIN2_O(pin2_o),
      .PIN2_OE(pin2_oe), .CNT_ONE_GATE_O(gate_o), .CNT_ONE_GATE_OE(gate_oe),
      .PORT_A_O(port_a_o), .PORT_A_OE(port_a_oe), .PORT_B_O(port_b_o), .PORT_B_OE(port_b_oe),
      .DAC_LOAD(dac_load), .DAC_TARGET(dac_tgt), .ACQ_BUSY(acq_busy), .ACQ_CLEAR(), .IRQ(irq),
      .DMA_REQ_A(req_a), .DMA_REQ_B(req_b));
   dcs_host_dma #(.XFER_CNT(4)) dcs_host_dma_inst (
      .CLK(clk), .RST(rst), .REQ_A(req_a), .REQ_B(req_b), .TC_A(tc_a), .TC_B(tc_b));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {16'h0000, d}, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, exp);
      check({31'h0, e}, {31'h0, exp_err});
   endtask

   // fire one dac update cause and watch for the load pulse
   task automatic dac_try(input int how, input logic exp);
      logic s;
      s = 1'b0;
      if (how == 0) dac_write <= 1'b1;
      if (how == 1) ext_dac_n <= 1'b0;
      if (how == 2) pin4_drv <= 1'b0;
      // watch alongside the strobe write so its pulse is not missed
      fork
         if (how == 3) wr(8'h10, 16'h0000);
         repeat (6) begin
            @(posedge clk);
            dac_write <= 1'b0;
            if (dac_load === 1'b1) s = 1'b1;
         end
      join
      ext_dac_n <= 1'b1;
      pin4_drv <= 1'b1;
      tick(3);
      check({31'h0, s}, {31'h0, exp});
   endtask

   task automatic acq_pulse(input logic fin);
      if (fin) acq_end <= 1'b1;
      else acq_start <= 1'b1;
      @(posedge clk);
      acq_start <= 1'b0;
      acq_end <= 1'b0;
      tick(3);
   endtask

   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      tick(20000);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      logic [31:0] t;
      int i;
      {rst, psel, penable, pwrite, dac_write, acq_start, acq_end, cnt_five, cnt_two} = 9'h100;
      {ext_dac_n, overrun_n, overflow_n, pin4_drv, pin2_drv} = 5'h1F;
      paddr = 8'h00;
      pwdata = 32'h0;
      fifo_level = 9'd0;
      tick(3);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h0000_2180, 1'b0);
      fifo_level <= 9'd128;
      rd_chk(8'h00, 32'h0000_1180, 1'b0);
      fifo_level <= 9'd127;
      rd_chk(8'h00, 32'h0000_3180, 1'b0);
      fifo_level <= 9'd0;
      rd_chk(8'h04, 32'h0, 1'b0);
      rd_chk(8'h1C, 32'h0, 1'b1);
      wr(8'h18, 16'h00A5);
      wr(8'h04, 16'hC005);
      for (i = 0; i < 2; i++) begin
         cnt_five <= i[0];
         cnt_two <= ~i[0];
         tick(3);
         check({22'h0, port_b_oe, port_a_oe, port_b_o, port_a_o}, 32'h3A5);
         check({28'h0, pin4_oe, pin2_oe, pin4_o, pin2_o}, {28'h3, i[0], ~i[0]});
      end
      wr(8'h04, 16'h0002);
      for (i = 0; i < 2; i++) begin
         pin2_drv <= i[0];
         tick(3);
         check({30'h0, gate_oe, gate_o}, {30'h1, i[0]});
      end
      wr(8'h04, 16'h0000);
      tick(2);
      check({27'h0, port_b_oe, port_a_oe, pin4_oe, pin2_oe, gate_oe}, 32'h0);
      dac_try(0, 1'b1);
      wr(8'h04, 16'h2000);
      dac_try(0, 1'b0);
      dac_try(1, 1'b1);
      dac_try(3, 1'b1);
      dac_try(2, 1'b0);
      wr(8'h04, 16'h2008);
      dac_try(2, 1'b1);
      dac_try(1, 1'b0);
      wr(8'h14, 16'h0000);
      for (i = 0; i < 17; i++) begin
         t = mode_tbl[i];
         fifo_level <= {1'b0, t[15:8]};
         wr(8'h04, t[31:16]);
         tick(3);
         check({27'h0, req_b, dac_tgt, irq, req_a & t[4]}, {27'h0, t[5], t[3:0]});
         fifo_level <= 9'd0;
         wr(8'h04, 16'h0000);
      end
      wr(8'h04, 16'h1980);
      ext_dac_n <= 1'b0;
      tick(3);
      check({30'h0, req_a, req_b}, 32'h3);
      tick(12);
      check({30'h0, req_a, req_b}, 32'h0);
      ext_dac_n <= 1'b1;
      wr(8'h04, 16'h0000);
      wr(8'h14, 16'h0000);
      wr(8'h0C, 16'h0000);
      wr(8'h04, 16'h0200);
      acq_pulse(1'b0);
      rd_chk(8'h00, 32'h0000_6180, 1'b0);
      acq_pulse(1'b1);
      check({31'h0, irq}, 32'h1);
      rd_chk(8'h00, 32'h0000_A180, 1'b0);
      wr(8'h04, 16'h0210);
      acq_pulse(1'b0);
      check({31'h0, acq_busy}, 32'h0);
      wr(8'h08, 16'h0000);
      tick(2);
      check({31'h0, irq}, 32'h0);
      acq_pulse(1'b0);
      check({31'h0, acq_busy}, 32'h1);
      overrun_n <= 1'b0;
      tick(3);
      rd_chk(8'h00, 32'h0000_A100, 1'b0);
      overrun_n <= 1'b1;
      wr(8'h04, 16'h0000);
      acq_pulse(1'b0);
      check({31'h0, acq_busy}, 32'h1);
      acq_pulse(1'b1);
      check({31'h0, irq}, 32'h0);
      wr(8'h08, 16'h0000);
      acq_pulse(1'b0);
      overflow_n <= 1'b0;
      tick(3);
      rd_chk(8'h00, 32'h0000_A080, 1'b0);
      check({31'h0, acq_busy}, 32'h0);
      overflow_n <= 1'b1;
      wr(8'h08, 16'h0000);
      wr(8'h04, 16'h0C00);
      fifo_level <= 9'd1;
      i = 0;
      while (irq !== 1'b1 && i < 30) begin
         @(posedge clk);
         i++;
      end
      check({31'h0, irq}, 32'h1);
      fifo_level <= 9'd0;
      tick(4);
      wr(8'h0C, 16'h0000);
      tick(2);
      check({31'h0, irq}, 32'h0);
      wr(8'h04, 16'h0800);
      fifo_level <= 9'd1;
      tick(30);
      check({31'h0, irq}, 32'h0);
      report_and_stop();
   end
endmodule // dcs_ctrl_tb

// ===== verification/dcs_host_dma.sv
// host dma controller model: terminal count pulse when a block count wraps
module dcs_host_dma #(
   parameter XFER_CNT = 4   // transfers per block, kept short
) (
   input  wire  CLK,        // system clock
   input  wire  RST,        // async reset, active high
   input  wire  REQ_A,      // request, channel a
   input  wire  REQ_B,      // request, channel b
   output logic TC_A,       // terminal count pulse, channel a
   output logic TC_B        // terminal count pulse, channel b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_a_q;
   logic [15:0] cnt_b_q;

   // one transfer per requesting cycle; auto-init reload keeps blocks coming
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cnt_a_q <= 16'(XFER_CNT - 1);
         cnt_b_q <= 16'(XFER_CNT - 1);
         TC_A    <= 1'b0;
         TC_B    <= 1'b0;
      end else begin
         TC_A <= REQ_A && cnt_a_q == 16'h0000;
         TC_B <= REQ_B && cnt_b_q == 16'h0000;
         if (REQ_A)
            cnt_a_q <= (cnt_a_q == 16'h0000) ? 16'(XFER_CNT - 1) : cnt_a_q - 16'h0001;
         if (REQ_B)
            cnt_b_q <= (cnt_b_q == 16'h0000) ? 16'(XFER_CNT - 1) : cnt_b_q - 16'h0001;
      end
   end
endmodule // dcs_host_dma
